// file: logic/hmb_mailbox.sv
// Dual channel host mailbox with fast gate-line control
//
// Function
// - Command/data flag follows select at write
// - Host write sets, CPU read clears input-full
// - Input-full: set on write rise, clear on read fall
// - CPU write sets, host read clears output-full
// - Output-full: set on write fall, clear on read rise
// - Input-full flags are CPU interrupt sources
// - Channel-2 write stores byte and command flag
// - Drive channel-2 output only during its read
// - Status resets to zero; hardware bits read-only
// - Bits 7-4 and 2 are CPU-writable user bits
// - Select picks output buffer or status; no overlap
// - Host write loads input buffer, command or data
// - Port works only while port enable is set
// - Control bit 0 enables hardware gate control
// - Hardware gate output starts at logic one
// - Only channel-1 writes steer the gate pin
// - Data after gate command drives pin from bit 1
// - Gate traffic raises no input-full flag
// - Other command cancels; repeated command restarts
// - Channel-1 write stores byte on write rise
// - Interrupts forwarded only when enable bit set
// - Control resets to F8, top bits read one
`timescale 1ns/1ps
`default_nettype none
module hmb_mailbox (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic standby,
    input wire logic host_port_enable,
    input wire logic gate_pin_direction,
    input wire logic sw_gate_level,
    input wire logic chan1_select_n,
    input wire logic chan2_select_n,
    input wire logic cmd_data_select,
    input wire logic host_read_n,
    input wire logic host_write_n,
    input wire logic [7:0] host_bus_in,
    output logic [7:0] host_bus_out,
    output logic host_bus_oe,
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_rd,
    input wire logic cpu_wr,
    input wire logic [7:0] cpu_wdata,
    output logic [7:0] cpu_rdata,
    output logic chan1_full_irq,
    output logic chan2_full_irq,
    output logic gate_line_out,
    output logic gate_line_oe
);
    import hmb_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0][7:0] ibuf;
        logic [1:0][7:0] obuf;
        logic [1:0][7:0] stat;
        logic [CTRL_BITS-1:0] ctrl;
        logic gate;
        logic pending;
        logic hrd_n_q;
        logic hwr_n_q;
        logic [1:0] hsel;
        logic cd_sel;
        logic [7:0] hbus;
        logic crd_q;
        logic cwr_q;
        logic [15:0] caddr;
        logic [7:0] cwdata;
        logic [7:0] rdata;
        logic [7:0] hdata;
        logic hoe;
    } hmb_state_s;

    localparam hmb_state_s ST_RESET = '{
        gate: GATE_INIT,
        hrd_n_q: 1'b1,
        hwr_n_q: 1'b1,
        default: '0
    };

    hmb_state_s s;
    hmb_state_s next_s;
    hmb_pin_if pin ();

    logic wr_rise;
    logic rd_rise;
    logic [1:0] wr_ev;
    logic cpu_rd_fall;
    logic cpu_wr_fall;
    logic hw_gate;

    hmb_sync u_sync (
        .clk_sys (clk_sys),
        .rst (rst),
        .pins_raw ({chan1_select_n, chan2_select_n, cmd_data_select,
                    host_read_n, host_write_n, host_bus_in}),
        .pin (pin)
    );

    // ------------------------------------------------------------------
    // Register decode, shared by read data and strobe edges
    // ------------------------------------------------------------------
    function automatic hmb_reg_e decode(input logic [15:0] a);
        case (a)
            ADDR_PORT_CONTROL: decode = HMB_REG_CTRL;
            ADDR_CHAN1_INPUT: decode = HMB_REG_IN1;
            ADDR_CHAN1_OUTPUT: decode = HMB_REG_OUT1;
            ADDR_CHAN1_STATUS: decode = HMB_REG_STAT1;
            ADDR_CHAN2_INPUT: decode = HMB_REG_IN2;
            ADDR_CHAN2_OUTPUT: decode = HMB_REG_OUT2;
            ADDR_CHAN2_STATUS: decode = HMB_REG_STAT2;
            default: decode = HMB_REG_NONE;
        endcase
    endfunction : decode

    // Host strobe edges are taken from synchronised copies only
    assign wr_rise = host_port_enable & ~s.hwr_n_q
                   & pin.host_write_n;
    assign rd_rise = host_port_enable & ~s.hrd_n_q
                   & pin.host_read_n;
    assign wr_ev = wr_rise ? s.hsel : 2'b00;
    assign cpu_rd_fall = host_port_enable & s.crd_q & ~cpu_rd;
    assign cpu_wr_fall = host_port_enable & s.cwr_q & ~cpu_wr;
    assign hw_gate = s.ctrl[CTRL_HW_GATE];

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        hmb_reg_e rreg;
        hmb_reg_e creg;
        logic is_cmd;
        logic gate_cmd;
        logic nop_cmd;
        logic raise;
        rreg = decode(cpu_addr);
        creg = decode(s.caddr);
        is_cmd = s.cd_sel;
        gate_cmd = is_cmd && (s.hbus == CMD_GATE_WRITE);
        nop_cmd = is_cmd && (s.hbus == CMD_GATE_NOP);
        raise = 1'b1;
        next_s = s;
        next_s.hrd_n_q = pin.host_read_n;
        next_s.hwr_n_q = pin.host_write_n;
        next_s.crd_q = cpu_rd;
        next_s.cwr_q = cpu_wr;

        // Latch address and data while a host strobe is low, since the
        // host may release them within a cycle of the rising edge
        if (!pin.host_write_n || !pin.host_read_n) begin
            next_s.hsel[0] = ~pin.chan1_select_n & pin.chan2_select_n;
            next_s.hsel[1] = pin.chan1_select_n & ~pin.chan2_select_n;
            next_s.cd_sel = pin.cmd_data_select;
            next_s.hbus = pin.host_bus;
        end
        if (cpu_rd || cpu_wr) begin
            next_s.caddr = cpu_addr;
        end
        if (cpu_wr) begin
            next_s.cwdata = cpu_wdata;
        end

        // Clears come first so a coinciding set wins
        if (cpu_rd_fall && creg == HMB_REG_IN1) begin
            next_s.stat[0][STAT_IN_FULL] = 1'b0;
        end
        if (cpu_rd_fall && creg == HMB_REG_IN2) begin
            next_s.stat[1][STAT_IN_FULL] = 1'b0;
        end
        for (int c = 0; c < 2; c++) begin
            if (rd_rise && s.hsel[c] && !s.cd_sel) begin
                next_s.stat[c][STAT_OUT_FULL] = 1'b0;
            end
        end

        // On-chip CPU writes take effect on the falling strobe edge
        if (cpu_wr_fall) begin
            case (creg)
                HMB_REG_CTRL: begin
                    next_s.ctrl = s.cwdata[CTRL_BITS-1:0];
                end
                HMB_REG_OUT1: begin
                    next_s.obuf[0] = s.cwdata;
                    next_s.stat[0][STAT_OUT_FULL] = 1'b1;
                end
                HMB_REG_OUT2: begin
                    next_s.obuf[1] = s.cwdata;
                    next_s.stat[1][STAT_OUT_FULL] = 1'b1;
                end
                HMB_REG_STAT1: begin
                    // Hardware bits come from next_s so a clear taken
                    // in this same cycle is not undone by the write
                    next_s.stat[0] = (next_s.stat[0] & ~STAT_USER_MASK)
                                   | (s.cwdata & STAT_USER_MASK);
                end
                HMB_REG_STAT2: begin
                    next_s.stat[1] = (next_s.stat[1] & ~STAT_USER_MASK)
                                   | (s.cwdata & STAT_USER_MASK);
                end
                default: begin
                end
            endcase
        end

        // Channel-1 host write, with the fast gate decoder
        if (wr_ev[0]) begin
            next_s.ibuf[0] = s.hbus;
            next_s.stat[0][STAT_CMD_DATA] = s.cd_sel;
            if (hw_gate) begin
                if (gate_cmd) begin
                    next_s.pending = 1'b1;
                    raise = 1'b0;
                end else if (!is_cmd && s.pending) begin
                    next_s.gate = s.hbus[GATE_DATA_BIT];
                    next_s.pending = 1'b0;
                    raise = 1'b0;
                end else begin
                    next_s.pending = 1'b0;
                    raise = !nop_cmd;
                end
            end
            if (raise) begin
                next_s.stat[0][STAT_IN_FULL] = 1'b1;
            end
        end

        // Channel-2 host write never reaches the gate decoder
        if (wr_ev[1]) begin
            next_s.ibuf[1] = s.hbus;
            next_s.stat[1][STAT_CMD_DATA] = s.cd_sel;
            next_s.stat[1][STAT_IN_FULL] = 1'b1;
        end

        // Registered read data for the on-chip CPU
        if (cpu_rd) begin
            case (host_port_enable ? rreg : HMB_REG_NONE)
                HMB_REG_CTRL: begin
                    next_s.rdata = CTRL_FIXED | 8'(s.ctrl);
                end
                HMB_REG_IN1: next_s.rdata = s.ibuf[0];
                HMB_REG_OUT1: next_s.rdata = s.obuf[0];
                HMB_REG_STAT1: next_s.rdata = s.stat[0];
                HMB_REG_IN2: next_s.rdata = s.ibuf[1];
                HMB_REG_OUT2: next_s.rdata = s.obuf[1];
                HMB_REG_STAT2: next_s.rdata = s.stat[1];
                default: next_s.rdata = 8'h00;
            endcase
        end

        // Host read path: select low on one channel only, no write
        next_s.hoe = host_port_enable && !pin.host_read_n
                   && pin.host_write_n
                   && (pin.chan1_select_n != pin.chan2_select_n);
        next_s.hdata = pin.cmd_data_select
                     ? s.stat[pin.chan1_select_n]
                     : s.obuf[pin.chan1_select_n];

        // Standby clears status and control like a reset
        if (standby) begin
            next_s.stat = {STAT_RESET, STAT_RESET};
            next_s.ctrl = CTRL_RESET;
            next_s.gate = GATE_INIT;
            next_s.pending = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s <= ST_RESET;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign host_bus_out = s.hdata;
    assign host_bus_oe = s.hoe;
    assign cpu_rdata = s.rdata;
    assign chan1_full_irq = s.stat[0][STAT_IN_FULL]
                          & s.ctrl[CTRL_IRQ1_EN];
    assign chan2_full_irq = s.stat[1][STAT_IN_FULL]
                          & s.ctrl[CTRL_IRQ2_EN];
    // Software mode lets the CPU drive the line through its port bit
    assign gate_line_out = hw_gate ? s.gate : sw_gate_level;
    assign gate_line_oe = gate_pin_direction;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_cmd_flag: assert property (wr_ev[0] && !standby
        |=> s.stat[0][STAT_CMD_DATA] == $past(s.cd_sel))
        else $error("command flag does not follow select");
    a_chan2_full: assert property (wr_ev[1] && !standby
        |=> s.stat[1][STAT_IN_FULL] && s.ibuf[1] == $past(s.hbus))
        else $error("channel 2 write not captured");
    a_in_clear: assert property (cpu_rd_fall && !wr_ev[0]
        && !standby && decode(s.caddr) == HMB_REG_IN1
        |=> !s.stat[0][STAT_IN_FULL])
        else $error("input full not cleared by cpu read");
    a_out_set: assert property (cpu_wr_fall && !standby
        && decode(s.caddr) == HMB_REG_OUT2
        |=> s.stat[1][STAT_OUT_FULL] && s.obuf[1] == $past(s.cwdata))
        else $error("output full not set by cpu write");
    a_out_clear: assert property (rd_rise && s.hsel[0]
        && !s.cd_sel && !cpu_wr_fall |=> !s.stat[0][STAT_OUT_FULL])
        else $error("output full not cleared by host read");
    a_bus_drive: assert property (host_bus_oe
        |-> $past(!pin.host_read_n && host_port_enable))
        else $error("host bus driven outside a read");
    a_ctrl_fixed: assert property (cpu_rd && host_port_enable
        && decode(cpu_addr) == HMB_REG_CTRL
        |=> cpu_rdata[7:3] == 5'h1F)
        else $error("control fixed bits not read as one");
    a_gate_data: assert property (wr_ev[0] && hw_gate
        && s.pending && !s.cd_sel && !standby && !cpu_wr_fall
        |=> gate_line_out == $past(s.hbus[GATE_DATA_BIT]) && !s.pending)
        else $error("gate pin not driven from data bit");
    a_gate_chan2: assert property (wr_ev[1] && !standby
        |=> $stable(s.gate) && $stable(s.pending))
        else $error("channel 2 write changed the gate");
    a_gate_quiet: assert property (wr_ev[0] && hw_gate && s.cd_sel
        && s.hbus == CMD_GATE_WRITE && !cpu_rd_fall && !standby
        |=> s.pending && $stable(s.stat[0][STAT_IN_FULL]))
        else $error("gate command raised input full");
    a_irq_raise: assert property (wr_ev[0] && !hw_gate
        && s.ctrl[CTRL_IRQ1_EN] && !cpu_wr_fall && !standby
        |=> chan1_full_irq)
        else $error("channel 1 interrupt not raised");

    c_gate_turn_on: cover property (wr_ev[0] && hw_gate && s.pending
        && !s.cd_sel && s.hbus[GATE_DATA_BIT]);
    c_host_read: cover property (rd_rise && s.hsel[1] && !s.cd_sel);
    c_set_clear_clash: cover property (wr_ev[0] && cpu_rd_fall);
    c_cpu_ctrl_write: cover property (cpu_wr_fall
        && decode(s.caddr) == HMB_REG_CTRL);
endmodule : hmb_mailbox
`default_nettype wire

// file: shared/hmb_pkg.sv
// Constants and types shared by the dual channel host mailbox
package hmb_pkg;
    // ------------------------------------------------------------------
    // On-chip CPU register addresses
    // ------------------------------------------------------------------
    localparam logic [15:0] ADDR_PORT_CONTROL = 16'hFFF0;
    localparam logic [15:0] ADDR_CHAN1_INPUT = 16'hFFF4;
    localparam logic [15:0] ADDR_CHAN1_OUTPUT = 16'hFFF5;
    localparam logic [15:0] ADDR_CHAN1_STATUS = 16'hFFF6;
    localparam logic [15:0] ADDR_CHAN2_INPUT = 16'hFFFC;
    localparam logic [15:0] ADDR_CHAN2_OUTPUT = 16'hFFFD;
    localparam logic [15:0] ADDR_CHAN2_STATUS = 16'hFFFE;

    // ------------------------------------------------------------------
    // Field layouts and reset values
    // ------------------------------------------------------------------
    localparam int STAT_OUT_FULL = 0;
    localparam int STAT_IN_FULL = 1;
    localparam int STAT_CMD_DATA = 3;
    localparam logic [7:0] STAT_USER_MASK = 8'hF4;
    localparam logic [7:0] STAT_RESET = 8'h00;
    localparam int CTRL_HW_GATE = 0;
    localparam int CTRL_IRQ1_EN = 1;
    localparam int CTRL_IRQ2_EN = 2;
    localparam int CTRL_BITS = 3;
    localparam logic [7:0] CTRL_FIXED = 8'hF8;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam int GATE_DATA_BIT = 1;
    localparam logic GATE_INIT = 1'b1;

    // ------------------------------------------------------------------
    // Host commands seen by the gate decoder
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_GATE_WRITE = 8'hD1;
    localparam logic [7:0] CMD_GATE_NOP = 8'hFF;

    // Synchronised host pins: 2 selects, command/data, 2 strobes, 8 data
    localparam int PIN_W = 13;
    localparam logic [PIN_W-1:0] PIN_IDLE = 13'h1FFF;

    typedef enum {
        HMB_REG_NONE,
        HMB_REG_CTRL,
        HMB_REG_IN1,
        HMB_REG_OUT1,
        HMB_REG_STAT1,
        HMB_REG_IN2,
        HMB_REG_OUT2,
        HMB_REG_STAT2
    } hmb_reg_e;
endpackage : hmb_pkg

// file: shared/hmb_pin_if.sv
// Synchronised host pins passed from the synchroniser to the mailbox core
`timescale 1ns/1ps
`default_nettype none
interface hmb_pin_if;
    logic chan1_select_n;
    logic chan2_select_n;
    logic cmd_data_select;
    logic host_read_n;
    logic host_write_n;
    logic [7:0] host_bus;
    modport src (
        output chan1_select_n, chan2_select_n, cmd_data_select,
        output host_read_n, host_write_n, host_bus
    );
    modport dst (
        input chan1_select_n, chan2_select_n, cmd_data_select,
        input host_read_n, host_write_n, host_bus
    );
endinterface : hmb_pin_if
`default_nettype wire

// file: logic/hmb_sync.sv
// Three-stage filtering synchroniser for the asynchronous host pins
`timescale 1ns/1ps
`default_nettype none
module hmb_sync (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [hmb_pkg::PIN_W-1:0] pins_raw,
    hmb_pin_if.src pin
);
    import hmb_pkg::*;

    typedef struct packed {
        logic [PIN_W-1:0] s1;
        logic [PIN_W-1:0] s2;
        logic [PIN_W-1:0] s3;
        logic [PIN_W-1:0] q;
    } hmb_sync_s;

    hmb_sync_s s;
    hmb_sync_s next_s;

    // ------------------------------------------------------------------
    // Filter: a bit moves only once stages two and three agree
    // ------------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.s1 = pins_raw;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        next_s.q = (s.s2 & s.s3) | (s.q & (s.s2 ^ s.s3));
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s <= '{s1: PIN_IDLE, s2: PIN_IDLE, s3: PIN_IDLE, q: PIN_IDLE};
        end else begin
            s <= next_s;
        end
    end

    assign pin.chan1_select_n = s.q[12];
    assign pin.chan2_select_n = s.q[11];
    assign pin.cmd_data_select = s.q[10];
    assign pin.host_read_n = s.q[9];
    assign pin.host_write_n = s.q[8];
    assign pin.host_bus = s.q[7:0];
endmodule : hmb_sync
`default_nettype wire

// file: testbench/hmb_host_model.sv
// Host processor model driving the mailbox strobe bus
`timescale 1ns/1ps
`default_nettype none
module hmb_host_model (
    input wire logic clk_sys,
    input wire logic [7:0] bus_in,
    input wire logic bus_oe,
    output logic chan1_select_n,
    output logic chan2_select_n,
    output logic cmd_data_select,
    output logic host_read_n,
    output logic host_write_n,
    output logic [7:0] bus_drive
);
    initial begin
        chan1_select_n = 1'b1;
        chan2_select_n = 1'b1;
        cmd_data_select = 1'b1;
        host_read_n = 1'b1;
        host_write_n = 1'b1;
        bus_drive = 8'hA5;
    end

    // ------------------------------------------------------------------
    // One strobe cycle; strobe held 7 clocks low, select 7 more after
    // ------------------------------------------------------------------
    task automatic access(input logic is_wr, input logic ch,
                          input logic a0, input logic [7:0] wdata,
                          output logic [7:0] rdata, output logic oe);
        @(negedge clk_sys);
        chan1_select_n = ch;
        chan2_select_n = !ch;
        cmd_data_select = a0;
        if (is_wr) begin
            bus_drive = wdata;
        end
        @(negedge clk_sys);
        // Only one strobe ever falls
        if (is_wr) begin
            host_write_n = 1'b0;
        end else begin
            host_read_n = 1'b0;
        end
        repeat (7) @(negedge clk_sys);
        rdata = bus_in;
        oe = bus_oe;
        host_write_n = 1'b1;
        host_read_n = 1'b1;
        repeat (7) @(negedge clk_sys);
        chan1_select_n = 1'b1;
        chan2_select_n = 1'b1;
        // Released bus shows the inverse so stale data cannot pass
        bus_drive = ~bus_drive;
    endtask : access
endmodule : hmb_host_model
`default_nettype wire

// file: testbench/hmb_mailbox_tb.sv
// Self-checking testbench for the dual channel host mailbox
`timescale 1ns/1ps
`default_nettype none
module hmb_mailbox_tb;
    import hmb_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic standby = 1'b0;
    logic host_port_enable = 1'b1;
    logic gate_pin_direction = 1'b1;
    logic sw_gate_level = 1'b1;
    logic [15:0] cpu_addr = 16'h0000;
    logic cpu_rd = 1'b0;
    logic cpu_wr = 1'b0;
    logic [7:0] cpu_wdata = 8'h00;
    logic c1n, c2n, cds, rdn, wrn, bus_oe, irq1, irq2, gate, gate_oe;
    logic [7:0] host_drive, host_bus, bus_out, cpu_rdata, rd;
    int n_mismatch = 0;
    int samples_checked = 0;

    always #20 clk_sys = ~clk_sys;
    assign host_bus = bus_oe ? bus_out : host_drive;

    hmb_host_model host (.clk_sys(clk_sys), .bus_in(host_bus),
        .bus_oe(bus_oe), .chan1_select_n(c1n), .chan2_select_n(c2n),
        .cmd_data_select(cds), .host_read_n(rdn), .host_write_n(wrn),
        .bus_drive(host_drive));
    hmb_mailbox dut (.clk_sys(clk_sys), .rst(rst), .standby(standby),
        .host_port_enable(host_port_enable),
        .gate_pin_direction(gate_pin_direction),
        .sw_gate_level(sw_gate_level), .chan1_select_n(c1n),
        .chan2_select_n(c2n), .cmd_data_select(cds), .host_read_n(rdn),
        .host_write_n(wrn), .host_bus_in(host_bus),
        .host_bus_out(bus_out), .host_bus_oe(bus_oe),
        .cpu_addr(cpu_addr), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr),
        .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
        .chan1_full_irq(irq1), .chan2_full_irq(irq2),
        .gate_line_out(gate), .gate_line_oe(gate_oe));

    // ------------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic cpu_write(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        cpu_addr = a;
        cpu_wdata = d;
        cpu_wr = 1'b1;
        @(negedge clk_sys);
        cpu_wr = 1'b0;
        repeat (2) @(negedge clk_sys);
    endtask : cpu_write

    task automatic cpu_chk(input logic [15:0] a, input logic [7:0] exp);
        @(negedge clk_sys);
        cpu_addr = a;
        cpu_rd = 1'b1;
        @(negedge clk_sys);
        cpu_rd = 1'b0;
        @(negedge clk_sys);
        chk(cpu_rdata, exp);
        @(negedge clk_sys);
    endtask : cpu_chk

    task automatic hw(input logic ch, input logic a0, input logic [7:0] d);
        logic o;
        host.access(1'b1, ch, a0, d, rd, o);
        repeat (4) @(negedge clk_sys);
    endtask : hw

    task automatic hr(input logic ch, input logic a0, input logic [7:0] exp);
        logic o;
        host.access(1'b0, ch, a0, 8'h00, rd, o);
        chk({7'h00, o}, 8'h01);
        chk(rd, exp);
        chk({7'h00, bus_oe}, 8'h00);
    endtask : hr

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        cpu_chk(ADDR_PORT_CONTROL, 8'hF8);
        cpu_chk(ADDR_CHAN1_STATUS, 8'h00);
        cpu_chk(ADDR_CHAN2_STATUS, 8'h00);
        chk({6'h00, irq2, irq1}, 8'h00);
        chk({7'h00, gate_oe}, 8'h01);
        gate_pin_direction = 1'b0;
        @(negedge clk_sys);
        chk({7'h00, gate_oe}, 8'h00);
        gate_pin_direction = 1'b1;
    endtask : t_reset

    task automatic t_chan1();
        cpu_write(ADDR_PORT_CONTROL, 8'h02);
        hw(1'b0, 1'b0, 8'h5A);
        cpu_chk(ADDR_CHAN1_STATUS, 8'h02);
        chk({7'h00, irq1}, 8'h01);
        cpu_chk(ADDR_CHAN1_INPUT, 8'h5A);
        cpu_chk(ADDR_CHAN1_STATUS, 8'h00);
        chk({7'h00, irq1}, 8'h00);
        cpu_write(ADDR_PORT_CONTROL, 8'h00);
    endtask : t_chan1

    task automatic t_chan2();
        hw(1'b1, 1'b1, 8'h33);
        chk({7'h00, irq2}, 8'h00);
        cpu_chk(ADDR_CHAN2_STATUS, 8'h0A);
        cpu_chk(ADDR_CHAN2_INPUT, 8'h33);
        cpu_write(ADDR_CHAN2_OUTPUT, 8'h9C);
        cpu_chk(ADDR_CHAN2_STATUS, 8'h09);
        hr(1'b1, 1'b1, 8'h09);
        hr(1'b1, 1'b0, 8'h9C);
        cpu_chk(ADDR_CHAN2_STATUS, 8'h08);
        hw(1'b1, 1'b0, 8'h44);
        cpu_chk(ADDR_CHAN2_STATUS, 8'h02);
        cpu_chk(ADDR_CHAN2_INPUT, 8'h44);
    endtask : t_chan2

    task automatic t_user();
        cpu_write(ADDR_CHAN1_STATUS, 8'hFF);
        cpu_chk(ADDR_CHAN1_STATUS, 8'hF4);
        hr(1'b0, 1'b1, 8'hF4);
        cpu_write(ADDR_CHAN1_OUTPUT, 8'h3C);
        cpu_chk(ADDR_CHAN1_STATUS, 8'hF5);
        hr(1'b0, 1'b0, 8'h3C);
        cpu_chk(ADDR_CHAN1_STATUS, 8'hF4);
        cpu_write(ADDR_CHAN1_STATUS, 8'h00);
        cpu_chk(ADDR_CHAN1_STATUS, 8'h00);
    endtask : t_user

    task automatic t_gate();
        sw_gate_level = 1'b0;
        @(negedge clk_sys);
        chk({7'h00, gate}, 8'h00);
        cpu_write(ADDR_PORT_CONTROL, 8'h01);
        chk({7'h00, gate}, 8'h01);
        hw(1'b0, 1'b1, CMD_GATE_WRITE);
        hw(1'b0, 1'b0, 8'h00);
        chk({7'h00, gate}, 8'h00);
        hw(1'b0, 1'b1, CMD_GATE_NOP);
        cpu_chk(ADDR_CHAN1_STATUS, 8'h08);
        hw(1'b0, 1'b1, CMD_GATE_WRITE);
        hw(1'b0, 1'b1, 8'h12);
        chk({7'h00, gate}, 8'h00);
        cpu_chk(ADDR_CHAN1_STATUS, 8'h0A);
        cpu_chk(ADDR_CHAN1_INPUT, 8'h12);
        hw(1'b0, 1'b1, CMD_GATE_WRITE);
        hw(1'b0, 1'b1, CMD_GATE_WRITE);
        hw(1'b0, 1'b0, 8'h02);
        chk({7'h00, gate}, 8'h01);
        cpu_chk(ADDR_CHAN1_STATUS, 8'h00);
        hw(1'b1, 1'b1, CMD_GATE_WRITE);
        hw(1'b1, 1'b0, 8'h00);
        chk({7'h00, gate}, 8'h01);
        cpu_chk(ADDR_CHAN2_INPUT, 8'h00);
        cpu_write(ADDR_PORT_CONTROL, 8'h00);
        sw_gate_level = 1'b1;
    endtask : t_gate

    task automatic t_disable();
        host_port_enable = 1'b0;
        hw(1'b0, 1'b0, 8'h77);
        cpu_write(ADDR_CHAN1_OUTPUT, 8'h55);
        cpu_chk(ADDR_PORT_CONTROL, 8'h00);
        host_port_enable = 1'b1;
        cpu_chk(ADDR_CHAN1_STATUS, 8'h00);
    endtask : t_disable

    task automatic t_standby();
        cpu_write(ADDR_PORT_CONTROL, 8'h07);
        cpu_write(ADDR_CHAN2_STATUS, 8'hF0);
        hw(1'b1, 1'b0, 8'h6B);
        chk({7'h00, irq2}, 8'h01);
        cpu_chk(ADDR_PORT_CONTROL, 8'hFF);
        standby = 1'b1;
        repeat (2) @(negedge clk_sys);
        standby = 1'b0;
        chk({7'h00, irq2}, 8'h00);
        repeat (2) @(negedge clk_sys);
        cpu_chk(ADDR_PORT_CONTROL, 8'hF8);
        cpu_chk(ADDR_CHAN2_STATUS, 8'h00);
    endtask : t_standby

    // ------------------------------------------------------------------
    // Verdict, watchdog and main sequence
    // ------------------------------------------------------------------
    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict

    // Whole run needs under 4000 clocks; allow a wide margin
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        give_verdict();
    end

    initial begin
        repeat (8) @(negedge clk_sys);
        rst = 1'b0;
        repeat (2) @(negedge clk_sys);
        t_reset();
        t_chan1();
        t_chan2();
        t_user();
        t_gate();
        t_disable();
        t_standby();
        give_verdict();
    end
endmodule : hmb_mailbox_tb
`default_nettype wire
